// file: sim/acs_host_model.sv
`timescale 1ns/10ps
module acs_host_model #(
  parameter int WIDTH = 16
) (
  input wire logic serial_clk, // master serial clock
  input wire logic frame_sync, // frame marker
  input wire logic serial_result_out, // serial data, msb first
  input wire logic clock_polarity_invert, // idle level of the serial clock
  output logic [WIDTH-1:0] word, // last word received
  output logic word_valid // pulses once a whole word is in
);
  int count = 0;
  logic [WIDTH-1:0] shift_q = '0;
  initial word = '0;
  initial word_valid = 1'b0;
  // ----------------------------------------
  // receiver
  // ----------------------------------------
  always @(posedge frame_sync) count = 0;
  // sample on the edge leaving idle; data only moves on the return edge
  always @(serial_clk) begin
    if (frame_sync === 1'b1 && serial_clk !== clock_polarity_invert) begin
      shift_q = {shift_q[WIDTH-2:0], serial_result_out};
      count++;
      if (count == WIDTH) begin
        word = shift_q;
        word_valid = 1'b1;
        #10 word_valid = 1'b0;
      end
    end
  end
endmodule // acs_host_model

// file: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import acs_pkg::*;
  localparam int T_CONV[3] = '{1500, 1750, 2000};
  localparam int T_SRA[3] = '{1000, 1250, 1500};
  localparam int T_SRD[3] = '{25, 275, 525};
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic strobe_n = 1'b1;
  acs_cfg_type cfg = '0;
  logic pol_inv = 1'b0;
  logic [15:0] sar_result = 16'h0000;
  logic busy, serial_clk, frame_sync, sdo, word_valid, busy_prev = 1'b0;
  logic [15:0] par_data, host_word, last_word = 16'h0000, par_prev = 16'h0000;
  logic [15:0] exp_par[$];
  logic [15:0] exp_ser[$];
  int fail_count = 0, checks = 0, seed = 27816, stab = 0;
  // ----------------------------------------
  // clocks and instances
  // ----------------------------------------
  always #2 sys_clk = ~sys_clk;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end
  acs_top u_acs_top (.SYS_CLK(sys_clk), .RESETN(resetn), .LINK_CLK(link_clk), .CONVERT_STROBE_N(strobe_n),
    .CFG(cfg), .CLOCK_POLARITY_INVERT(pol_inv), .SAR_RESULT(sar_result), .BUSY(busy), .PAR_DATA(par_data),
    .SERIAL_CLK(serial_clk), .FRAME_SYNC(frame_sync), .SERIAL_RESULT_OUT(sdo));
  acs_host_model u_acs_host_model (.serial_clk(serial_clk), .frame_sync(frame_sync), .serial_result_out(sdo),
    .clock_polarity_invert(pol_inv), .word(host_word), .word_valid(word_valid));
  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic fail_now(input string msg);
    $display("wrong value at %0t: %s", $time, msg);
    fail_count++;
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) fail_now($sformatf("%s %h not %h", what, got, exp));
  endtask
  task automatic cmp_range(input int val, input int lo, input int hi, input string what);
    checks++;
    if (val < lo || val > hi) fail_now($sformatf("%s %0d not in %0d..%0d", what, val, lo, hi));
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // result monitors
  // ----------------------------------------
  always @(negedge sys_clk) begin
    stab = (par_data !== par_prev) ? 0 : stab + 1;
    par_prev = par_data;
    if (busy_prev === 1'b1 && busy === 1'b0) begin
      cmp_range(stab * 4, 45, 100000, "data before busy low");
      if (exp_par.size() == 0) fail_now("extra conversion");
      else cmp_word(par_data, exp_par.pop_front(), "parallel word");
    end
    busy_prev = busy;
  end
  always @(posedge word_valid) begin
    if (exp_ser.size() == 0) fail_now("extra serial word");
    else cmp_word(host_word, exp_ser.pop_front(), "serial word");
  end
  // ----------------------------------------
  // one conversion, timed from the strobe edge
  // ----------------------------------------
  task automatic convert(input int m, input bit ser, input bit ra, input bit pol, input bit extra);
    int c = 0, t_br = -1, t_bf = -1, t_fr = -1, t_ff = -1, t_par = -1;
    bit again = 1'b0;
    logic [15:0] w;
    w = $random(seed);
    if (w === last_word) w = ~w;
    cfg.mode_pins = (m == 2) ? {1'b1, w[0]} : m[1:0];
    cfg.ser_enable = ser;
    cfg.read_after = ra;
    pol_inv = pol;
    sar_result = w;
    exp_par.push_back(w);
    if (ser) exp_ser.push_back(ra ? w : last_word);
    // straps and polarity settle through their synchronisers first
    repeat (3) @(posedge link_clk);
    @(negedge sys_clk);
    strobe_n = 1'b0;
    while (c < 3000 && (busy || frame_sync || c < 563)) begin
      @(negedge sys_clk);
      c++;
      if (c == 3 || c == 103) strobe_n = 1'b1;
      if (extra && c == 100) strobe_n = 1'b0;
      if (busy && t_bf >= 0) again = 1'b1;
      if (busy && t_br < 0) t_br = c;
      if (!busy && t_br >= 0 && t_bf < 0) t_bf = c;
      if (frame_sync && t_fr < 0) t_fr = c;
      if (!frame_sync && t_fr >= 0 && t_ff < 0) t_ff = c;
      if (par_data === w && t_par < 0) t_par = c;
    end
    if (c >= 3000) begin
      fail_now("conversion hung");
      tally_and_finish();
    end
    cmp_range(t_br * 4, 0, 25, "strobe to busy");
    cmp_range(int'(again), 0, 0, "busy restarted");
    if (!(ser && ra)) begin
      cmp_range((t_bf - t_br) * 4, 0, T_CONV[m], "busy width");
      cmp_range(t_par * 4, 0, T_CONV[m], "strobe to data");
    end else begin
      cmp_range(t_bf - t_ff, 1, 1000, "busy covers frame");
      cmp_range((t_bf - t_ff) * 4, 45, 250, "frame end to busy low");
      cmp_range(t_fr * 4, T_SRA[m] - 20, T_SRA[m] + 300, "strobe to frame");
    end
    if (ser && !ra) cmp_range(t_fr * 4, T_SRD[m] - 20, T_SRD[m] + 300, "strobe to frame");
    if (ser) cmp_word({15'h0000, serial_clk}, {15'h0000, pol}, "idle clock");
    last_word = w;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(negedge sys_clk);
    // the link logic needs two of its own edges inside reset
    repeat (2) @(posedge link_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int m = 0; m < 3; m++) begin
      convert(m, 1'b0, 1'b0, 1'b0, m == 1);
      convert(m, 1'b1, 1'b1, m[0], 1'b0);
      convert(m, 1'b1, 1'b0, ~m[0], 1'b0);
    end
    repeat (50) @(negedge sys_clk);
    if (exp_par.size() + exp_ser.size() != 0) fail_now("results missing");
    tally_and_finish();
  end
endmodule // tb_top

// file: verilog/acs_defines.svh
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
// ----------------------------------------
// clock and cycle conversion (times in ps)
// ----------------------------------------
`define ACS_CLK_PS 4000
`define ACS_CYC_UP(t) (((t) + `ACS_CLK_PS - 1) / `ACS_CLK_PS)
`define ACS_CYC_DN(t) (((t) / `ACS_CLK_PS) < 1 ? 1 : ((t) / `ACS_CLK_PS))
// ----------------------------------------
// timing figures
// ----------------------------------------
`define ACS_T_CONV_F 1500000
`define ACS_T_CONV_N 1750000
`define ACS_T_CONV_L 2000000
`define ACS_T_DV2BUSY 45000
`define ACS_T_SYNC_RAC_F 1000000
`define ACS_T_SYNC_RAC_N 1250000
`define ACS_T_SYNC_RAC_L 1500000
`define ACS_T_SYNC_RDC_F 25000
`define ACS_T_SYNC_RDC_N 275000
`define ACS_T_SYNC_RDC_L 525000
`define ACS_T_SYNC2BUSY 50000
// cycles from the strobe pin to the start decision (two sync stages plus edge detect)
`define ACS_SYNC_LAT 3
// ----------------------------------------
// widths and pin codes
// ----------------------------------------
`define ACS_WORD_BITS 16
`define ACS_CNT_BITS 10
`define ACS_MODE_PIN_FAST 2'h0
`define ACS_MODE_PIN_NORMAL 2'h1
`endif

// file: verilog/acs_pkg.sv
package acs_pkg;
  typedef enum logic [1:0] {ACS_FAST, ACS_NORMAL, ACS_LOWPWR} acs_mode_type;
  typedef enum logic [2:0] {ST_IDLE, ST_CONV, ST_HOLD, ST_XFER, ST_TAIL} acs_state_type;
  typedef struct packed {
    logic [1:0] mode_pins;
    logic ser_enable;
    logic read_after;
  } acs_cfg_type;
endpackage

// file: verilog/acs_top.sv
`timescale 1ns/10ps
`include "acs_defines.svh"
module acs_top #(
  parameter int DATA_WIDTH = `ACS_WORD_BITS
) (
  input wire logic SYS_CLK, // conversion clock
  input wire logic RESETN, // async reset, active low
  input wire logic LINK_CLK, // serial bit clock source
  input wire logic CONVERT_STROBE_N, // convert strobe pin
  input acs_pkg::acs_cfg_type CFG, // mode and interface strap pins
  input wire logic CLOCK_POLARITY_INVERT, // serial clock polarity pin
  input wire logic [DATA_WIDTH-1:0] SAR_RESULT, // converter core result
  output logic BUSY, // conversion in progress
  output logic [DATA_WIDTH-1:0] PAR_DATA, // parallel result
  output logic SERIAL_CLK, // master serial clock
  output logic FRAME_SYNC, // serial frame marker
  output logic SERIAL_RESULT_OUT // serial data, msb first
);
  import acs_pkg::*;
  localparam int BW = $clog2(DATA_WIDTH + 1);
  localparam int TAIL = `ACS_CYC_DN(`ACS_T_SYNC2BUSY);
  localparam int DVB = `ACS_CYC_UP(`ACS_T_DV2BUSY);
  generate
    if (DATA_WIDTH < 2 || DATA_WIDTH > 32) begin : g_chk
      $error("DATA_WIDTH out of range");
    end
  endgenerate

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  function automatic int pick(acs_mode_type m, int f, int n, int l);
    unique case (m)
      ACS_FAST: return f;
      ACS_NORMAL: return n;
      ACS_LOWPWR: return l;
      default: return l;
    endcase
  endfunction

  function automatic acs_mode_type decode_mode(logic [1:0] p);
    if (p == `ACS_MODE_PIN_FAST) return ACS_FAST;
    if (p == `ACS_MODE_PIN_NORMAL) return ACS_NORMAL;
    return ACS_LOWPWR;
  endfunction

  // conversion phase length, chosen so busy and the frame marker meet their marks
  function automatic logic [`ACS_CNT_BITS-1:0] conv_len(acs_mode_type m, logic rac);
    if (rac)
      return `ACS_CNT_BITS'(pick(m, `ACS_CYC_DN(`ACS_T_SYNC_RAC_F), `ACS_CYC_DN(`ACS_T_SYNC_RAC_N),
                                 `ACS_CYC_DN(`ACS_T_SYNC_RAC_L)) - `ACS_SYNC_LAT);
    return `ACS_CNT_BITS'(pick(m, `ACS_CYC_DN(`ACS_T_CONV_F), `ACS_CYC_DN(`ACS_T_CONV_N),
                               `ACS_CYC_DN(`ACS_T_CONV_L)) - DVB - `ACS_SYNC_LAT);
  endfunction

  function automatic logic [`ACS_CNT_BITS-1:0] rdc_len(acs_mode_type m);
    return `ACS_CNT_BITS'(pick(m, `ACS_CYC_DN(`ACS_T_SYNC_RDC_F), `ACS_CYC_DN(`ACS_T_SYNC_RDC_N),
                               `ACS_CYC_DN(`ACS_T_SYNC_RDC_L)) - `ACS_SYNC_LAT);
  endfunction

  function automatic logic [`ACS_CNT_BITS-1:0] busy_max(acs_mode_type m);
    return `ACS_CNT_BITS'(pick(m, `ACS_CYC_DN(`ACS_T_CONV_F), `ACS_CYC_DN(`ACS_T_CONV_N),
                               `ACS_CYC_DN(`ACS_T_CONV_L)));
  endfunction

  // ----------------------------------------
  // pin and link ack synchronisers (system domain)
  // ----------------------------------------
  logic strobe_s1, strobe_s2, strobe_s3;
  acs_cfg_type cfg_s1, cfg_s2;
  logic ack_s1, ack_s2;
  // sequencer state and link ack are read here, so they are declared ahead of their own sections
  acs_state_type state_q;
  logic ack_l_q;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      strobe_s1 <= 1'b1;
      strobe_s2 <= 1'b1;
      strobe_s3 <= 1'b1;
      cfg_s1 <= '0;
      cfg_s2 <= '0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      strobe_s1 <= CONVERT_STROBE_N;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
      cfg_s1 <= CFG;
      cfg_s2 <= cfg_s1;
      ack_s1 <= ack_l_q;
      ack_s2 <= ack_s1;
    end
  end

  wire strobe_fell = strobe_s3 && !strobe_s2;
  // host keeps strobe spacing; nothing here enforces it beyond dropping strobes while busy
  wire start = strobe_fell && state_q == ST_IDLE;

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  logic [`ACS_CNT_BITS-1:0] cnt_q, busy_cnt_q;
  acs_mode_type mode_q;
  logic rac_q, ser_q, busy_q, dv_q, req_q;
  logic [DATA_WIDTH-1:0] result_q, tx_word_q;
  wire link_free = ack_s2 == req_q;
  wire rdc_launch = state_q == ST_CONV && ser_q && !rac_q && cnt_q == rdc_len(mode_q) && link_free;
  wire conv_end = state_q == ST_CONV && cnt_q == conv_len(mode_q, rac_q) - 1'b1;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      busy_q <= 1'b0;
      mode_q <= ACS_FAST;
      rac_q <= 1'b0;
      ser_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_CONV;
            busy_q <= 1'b1;
            cnt_q <= '0;
            mode_q <= decode_mode(cfg_s2.mode_pins);
            ser_q <= cfg_s2.ser_enable;
            rac_q <= cfg_s2.ser_enable && cfg_s2.read_after;
          end
        end
        ST_CONV: begin
          if (conv_end) begin
            state_q <= rac_q ? ST_XFER : ST_HOLD;
            cnt_q <= '0;
          end
        end
        ST_HOLD: begin
          // result has stood DVB cycles before busy drops
          if (cnt_q == `ACS_CNT_BITS'(DVB - 1)) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        ST_XFER: begin
          if (link_free) begin
            state_q <= ST_TAIL;
            cnt_q <= '0;
          end
        end
        ST_TAIL: begin
          if (cnt_q == `ACS_CNT_BITS'(TAIL - 1)) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // result capture and the word handed to the link; rdc_launch waits for the link ack, but a rac_q conversion end reloads tx_word without waiting
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      result_q <= '0;
      tx_word_q <= '0;
      req_q <= 1'b0;
      dv_q <= 1'b0;
    end else begin
      if (start)
        dv_q <= 1'b0;
      if (conv_end) begin
        result_q <= SAR_RESULT;
        dv_q <= 1'b1;
      end
      if (conv_end && rac_q) begin
        tx_word_q <= SAR_RESULT;
        req_q <= ~req_q;
      end else if (rdc_launch) begin
        tx_word_q <= result_q;
        req_q <= ~req_q;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN)
      busy_cnt_q <= '0;
    else
      busy_cnt_q <= busy_q ? busy_cnt_q + 1'b1 : '0;
  end

  assign BUSY = busy_q;
  assign PAR_DATA = result_q;

  // ----------------------------------------
  // serial master (link domain)
  // ----------------------------------------
  logic req_l_s1, req_l_s2, inv_s1, inv_s2;
  logic sclk_q, frame_q, sdo_q;
  logic [DATA_WIDTH-1:0] sh_q;
  logic [BW-1:0] bits_q;
  always_ff @(posedge LINK_CLK or negedge RESETN) begin
    if (!RESETN) begin
      req_l_s1 <= 1'b0;
      req_l_s2 <= 1'b0;
      inv_s1 <= 1'b0;
      inv_s2 <= 1'b0;
    end else begin
      req_l_s1 <= req_q;
      req_l_s2 <= req_l_s1;
      inv_s1 <= CLOCK_POLARITY_INVERT;
      inv_s2 <= inv_s1;
    end
  end

  // one bit per two link cycles: the serial clock is a toggling flop so it stays glitch free
  always_ff @(posedge LINK_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sclk_q <= 1'b0;
      frame_q <= 1'b0;
      sdo_q <= 1'b0;
      sh_q <= '0;
      bits_q <= '0;
      ack_l_q <= 1'b0;
    end else if (!frame_q) begin
      sclk_q <= inv_s2;
      if (req_l_s2 != ack_l_q) begin
        sh_q <= tx_word_q;
        sdo_q <= tx_word_q[DATA_WIDTH-1];
        frame_q <= 1'b1;
        bits_q <= BW'(DATA_WIDTH);
      end
    end else if (sclk_q == inv_s2) begin
      sclk_q <= ~inv_s2;
    end else begin
      sclk_q <= inv_s2;
      if (bits_q == BW'(1)) begin
        frame_q <= 1'b0;
        ack_l_q <= req_l_s2;
      end else begin
        sh_q <= {sh_q[DATA_WIDTH-2:0], 1'b0};
        sdo_q <= sh_q[DATA_WIDTH-2];
        bits_q <= bits_q - 1'b1;
      end
    end
  end

  assign SERIAL_CLK = sclk_q;
  assign FRAME_SYNC = frame_q;
  assign SERIAL_RESULT_OUT = sdo_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_busy_rise;
    @(posedge SYS_CLK) disable iff (!RESETN) start |=> busy_q;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not raised after start");

  property p_busy_short;
    @(posedge SYS_CLK) disable iff (!RESETN) busy_q && !rac_q |-> busy_cnt_q < busy_max(mode_q) - 2'd3;
  endproperty
  a_busy_short: assert property (p_busy_short) else $error("busy too long");

  property p_rac_tail;
    @(posedge SYS_CLK) disable iff (!RESETN)
      state_q == ST_XFER && link_free |-> ##12 busy_q ##1 !busy_q;
  endproperty
  a_rac_tail: assert property (p_rac_tail) else $error("busy end after transfer off");

  property p_data_time;
    @(posedge SYS_CLK) disable iff (!RESETN) $rose(dv_q) |-> busy_cnt_q <= busy_max(mode_q) - 2'd3;
  endproperty
  a_data_time: assert property (p_data_time) else $error("result late");

  property p_data_lead;
    @(posedge SYS_CLK) disable iff (!RESETN) $fell(busy_q) && !rac_q |-> $past(dv_q, 12);
  endproperty
  a_data_lead: assert property (p_data_lead) else $error("result not ahead of busy");

  property p_rac_launch;
    @(posedge SYS_CLK) disable iff (!RESETN)
      $changed(req_q) && rac_q |-> busy_cnt_q == conv_len(mode_q, 1'b1);
  endproperty
  a_rac_launch: assert property (p_rac_launch) else $error("late frame launch");

  property p_rdc_launch;
    @(posedge SYS_CLK) disable iff (!RESETN)
      $changed(req_q) && !rac_q |-> busy_cnt_q == rdc_len(mode_q) + 1'b1;
  endproperty
  a_rdc_launch: assert property (p_rdc_launch) else $error("early frame launch");

  property p_edge_ref;
    @(posedge LINK_CLK) disable iff (!RESETN) frame_q && $changed(sdo_q) |-> sclk_q == inv_s2;
  endproperty
  a_edge_ref: assert property (p_edge_ref) else $error("data moved on sampling edge");

  property p_ignore;
    @(posedge SYS_CLK) disable iff (!RESETN)
      strobe_fell && busy_q |=> busy_cnt_q == $past(busy_cnt_q) + 1'b1;
  endproperty
  a_ignore: assert property (p_ignore) else $error("strobe restarted busy");

  c_par: cover property (@(posedge SYS_CLK) disable iff (!RESETN) $fell(busy_q) && !ser_q);
  c_rac: cover property (@(posedge SYS_CLK) disable iff (!RESETN) state_q == ST_TAIL);
  c_rdc: cover property (@(posedge SYS_CLK) disable iff (!RESETN) rdc_launch);
  c_ign: cover property (@(posedge SYS_CLK) disable iff (!RESETN) strobe_fell && busy_q);
endmodule // acs_top
